//--- ihbp_pkg.sv
// Shared constants and types of the indirect host bus port.
// Assumes one system clock; host pins are asynchronous to it.
package ihbp_pkg;
   localparam int DATA_W = 16;
   localparam int BYTE_W = 8;
   localparam int INDEX_W = 8;
   localparam int SYNC_W = 22;
   // Function field of the pin configuration
   localparam logic [1:0] PIN_FN_TEAR = 2'h0;
   localparam logic [1:0] PIN_FN_IRQ = 2'h1;
   // Reset values
   localparam logic [DATA_W-1:0] DATA_RESET = 16'h0000;
   localparam logic [INDEX_W-1:0] INDEX_RESET = 8'h00;
   localparam logic [BYTE_W-1:0] BYTE_ZERO = 8'h00;
   // Idle levels of the synchronised inputs: select and strobes high, rest low
   localparam logic [SYNC_W-1:0] SYNC_IDLE = 22'h38_0000;
   typedef enum logic [1:0] {
      IHBP_IDLE  = 2'b00,
      IHBP_WRITE = 2'b01,
      IHBP_READ  = 2'b10
   } ihbp_state_type;
endpackage

//--- ihbp_sync.sv
// Three-stage input synchroniser with agreement filter.
// Assumes inputs are asynchronous to clk and a synchronous reset copy.
`timescale 1ns/1ps
module ihbp_sync #(
   parameter int              W    = 1,
   parameter logic [W-1:0]    INIT = '0
) (
   // Clock and reset
   input  wire logic          clk,
   input  wire logic          rstN,
   // Levels
   input  wire logic [W-1:0]  d,
   output logic      [W-1:0]  q
);
   logic [W-1:0] s1;
   logic [W-1:0] s2;
   logic [W-1:0] s3;

   always_ff @(posedge clk or negedge rstN) begin
      if (!rstN) begin
         s1 <= INIT;
         s2 <= INIT;
         s3 <= INIT;
      end else begin
         s1 <= d;
         s2 <= s1;
         s3 <= s2;
      end
   end

   // A change counts only once stages two and three agree
   genvar i;
   generate
      for (i = 0; i < W; i++) begin : g_bit
         always_ff @(posedge clk or negedge rstN) begin
            if (!rstN) begin
               q[i] <= INIT[i];
            end else if (s2[i] == s3[i]) begin
               q[i] <= s3[i];
            end
         end
      end
   endgenerate
endmodule

//--- ihbp_port.sv
// Indirect asynchronous host port: strobe bus or latch-enable bus,
// 8 or 16 bits, plus the tear/interrupt output pin.
// Assumes register decode and storage sit behind the internal side.
`timescale 1ns/1ps
module ihbp_port (
   // Clock and reset
   input  wire logic                            mclk,
   input  wire logic                            rst_n,
   // Configuration
   input  wire logic                            busWidthStrap,
   input  wire logic                            latchBusSelect,
   input  wire logic                            powerSaveEnable,
   input  wire logic [1:0]                      pinFunctionConfig,
   // Host control pins
   input  wire logic                            hostSelectN,
   input  wire logic                            hostWriteStrobeN,
   input  wire logic                            hostReadStrobeN,
   input  wire logic                            indexOrDataSelect,
   input  wire logic                            hostLatchEnable,
   // Host data pins
   input  wire logic [ihbp_pkg::BYTE_W-1:0]     hostDataLowerIn,
   input  wire logic [ihbp_pkg::BYTE_W-1:0]     hostDataUpperIn,
   output logic      [ihbp_pkg::BYTE_W-1:0]     hostDataLowerOut,
   output logic      [ihbp_pkg::BYTE_W-1:0]     hostDataUpperOut,
   output logic                                 hostDataOeN,
   // Internal register side
   output logic                                 indexWrite,
   output logic                                 dataWrite,
   output logic      [ihbp_pkg::DATA_W-1:0]     writeData,
   output logic      [ihbp_pkg::INDEX_W-1:0]    regIndex,
   output logic                                 readStrobe,
   input  wire logic                            indexIsMemory,
   input  wire logic [ihbp_pkg::DATA_W-1:0]     readData,
   // Pin status sources
   input  wire logic                            verticalBlankPeriod,
   input  wire logic                            horizontalBlankPeriod,
   input  wire logic                            irqRequest,
   output logic                                 tearOrIrqOut
);
   import ihbp_pkg::*;

   logic                rstMeta;
   logic                rstSyncN;
   logic [SYNC_W-1:0]   rawIn;
   logic [SYNC_W-1:0]   syncIn;
   logic [BYTE_W-1:0]   upperGated;
   logic [DATA_W-1:0]   dataS;
   logic                csS;
   logic                weS;
   logic                reS;
   logic                aleS;
   logic                dcS;
   logic                wide16;
   logic                aleLast;
   logic                dcLatched;
   logic                kindIsData;
   logic [DATA_W-1:0]   dataHold;
   logic [DATA_W-1:0]   readHold;
   ihbp_state_type      state;

   // Reset release through two flops
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         rstMeta  <= 1'b0;
         rstSyncN <= 1'b0;
      end else begin
         rstMeta  <= 1'b1;
         rstSyncN <= rstMeta;
      end
   end

   // Gating ahead of the synchroniser
   always_comb begin
      upperGated = busWidthStrap ? hostDataUpperIn : BYTE_ZERO;
      rawIn = {hostSelectN, hostWriteStrobeN, hostReadStrobeN,
               hostLatchEnable, indexOrDataSelect, busWidthStrap,
               upperGated, hostDataLowerIn};
   end

   ihbp_sync #(
      .W    (SYNC_W),
      .INIT (SYNC_IDLE)
   ) u_sync (
      .clk  (mclk),
      .rstN (rstSyncN),
      .d    (rawIn),
      .q    (syncIn)
   );

   always_comb begin
      csS    = syncIn[21];
      weS    = syncIn[20];
      reS    = syncIn[19];
      aleS   = syncIn[18];
      dcS    = syncIn[17];
      wide16 = syncIn[16];
      // Data ignored while chip select is high
      dataS  = csS ? DATA_RESET : syncIn[15:0];
   end

   // Latch-enable bus: select level caught on latch rise
   always_ff @(posedge mclk or negedge rstSyncN) begin
      if (!rstSyncN) begin
         aleLast   <= 1'b0;
         dcLatched <= 1'b0;
      end else begin
         aleLast <= aleS;
         if (aleS && !aleLast) begin
            dcLatched <= dcS;
         end
      end
   end

   // Strobe bus reads the select level directly
   always_comb begin
      kindIsData = latchBusSelect ? dcLatched : dcS;
   end

   // Transfer sequencer
   always_ff @(posedge mclk or negedge rstSyncN) begin
      if (!rstSyncN) begin
         state <= IHBP_IDLE;
      end else begin
         unique case (state)
            IHBP_IDLE: begin
               if (!csS && !weS) begin
                  state <= IHBP_WRITE;
               end else if (!csS && !reS) begin
                  state <= IHBP_READ;
               end
            end
            IHBP_WRITE: begin
               if (csS || weS) begin
                  state <= IHBP_IDLE;
               end
            end
            IHBP_READ: begin
               if (csS || reS) begin
                  state <= IHBP_IDLE;
               end
            end
            default: begin
               state <= IHBP_IDLE;
            end
         endcase
      end
   end

   // Write path: data held during strobe, taken at its end
   always_ff @(posedge mclk or negedge rstSyncN) begin
      if (!rstSyncN) begin
         dataHold   <= DATA_RESET;
         writeData  <= DATA_RESET;
         regIndex   <= INDEX_RESET;
         indexWrite <= 1'b0;
         dataWrite  <= 1'b0;
      end else begin
         indexWrite <= 1'b0;
         dataWrite  <= 1'b0;
         if (state == IHBP_WRITE && !csS && !weS) begin
            dataHold <= wide16 ? dataS : {BYTE_ZERO, dataS[7:0]};
         end
         if (state == IHBP_WRITE && (csS || weS)) begin
            writeData <= dataHold;
            if (kindIsData) begin
               dataWrite <= 1'b1;
            end else begin
               indexWrite <= 1'b1;
               regIndex   <= dataHold[INDEX_W-1:0];
            end
         end
      end
   end

   // Read path: register data only; memory reads return zero
   always_ff @(posedge mclk or negedge rstSyncN) begin
      if (!rstSyncN) begin
         readHold   <= DATA_RESET;
         readStrobe <= 1'b0;
      end else begin
         readStrobe <= 1'b0;
         if (state == IHBP_IDLE && !csS && weS && !reS) begin
            readStrobe <= !indexIsMemory;
         end
         if (state == IHBP_READ) begin
            readHold <= indexIsMemory ? DATA_RESET : readData;
         end
      end
   end

   always_ff @(posedge mclk or negedge rstSyncN) begin
      if (!rstSyncN) begin
         hostDataLowerOut <= BYTE_ZERO;
         hostDataUpperOut <= BYTE_ZERO;
      end else begin
         hostDataLowerOut <= readHold[7:0];
         hostDataUpperOut <= wide16 ? readHold[15:8] : BYTE_ZERO;
      end
   end

   // Drive only while raw select and read are low and a read is live
   always_comb begin
      hostDataOeN = !(rstSyncN && state == IHBP_READ && !hostSelectN
                      && !hostReadStrobeN);
   end

   // Tear or interrupt pin
   always_ff @(posedge mclk or negedge rstSyncN) begin
      if (!rstSyncN) begin
         tearOrIrqOut <= 1'b0;
      end else if (powerSaveEnable) begin
         tearOrIrqOut <= 1'b0;
      end else if (pinFunctionConfig == PIN_FN_TEAR) begin
         tearOrIrqOut <= verticalBlankPeriod || horizontalBlankPeriod;
      end else if (pinFunctionConfig == PIN_FN_IRQ) begin
         tearOrIrqOut <= irqRequest;
      end else begin
         tearOrIrqOut <= 1'b0;
      end
   end

   default clocking cb @(posedge mclk);
   endclocking
   default disable iff (!rstSyncN);

   sequence writeEnds;
      state == IHBP_WRITE && (csS || weS);
   endsequence

   chk_upper_gated: assert property (
      writeEnds ##0 !wide16 |=> writeData[15:8] == BYTE_ZERO)
      else $error("upper byte not gated in 8-bit mode");
   chk_select_ignored: assert property (
      state == IHBP_IDLE && csS |=> !indexWrite && !dataWrite)
      else $error("write taken while deselected");
   chk_latch_capture: assert property (
      aleS && !aleLast |=> dcLatched == $past(dcS))
      else $error("select level not caught on latch rise");
   chk_write_kind: assert property (
      writeEnds |=> (indexWrite ^ dataWrite)
                    && dataWrite == $past(kindIsData))
      else $error("write end gave wrong pulse");
   chk_read_request: assert property (
      readStrobe |-> state == IHBP_READ && !$past(reS))
      else $error("read request without read strobe");
   chk_no_memory_read: assert property (
      state == IHBP_READ && indexIsMemory |=> readHold == DATA_RESET)
      else $error("memory data read back");
   chk_drive_window: assert property (
      !hostDataOeN |-> !hostSelectN && !hostReadStrobeN)
      else $error("bus driven outside read");
   chk_tear_default: assert property (
      !powerSaveEnable && pinFunctionConfig == PIN_FN_TEAR
      |=> tearOrIrqOut == ($past(verticalBlankPeriod)
                           || $past(horizontalBlankPeriod)))
      else $error("tear output wrong");
   chk_irq_mode: assert property (
      !powerSaveEnable && pinFunctionConfig == PIN_FN_IRQ
      |=> tearOrIrqOut == $past(irqRequest))
      else $error("interrupt output wrong");
   chk_save_stops: assert property (
      powerSaveEnable [*2] |-> !tearOrIrqOut)
      else $error("pin active in power save");
endmodule

//--- ihbp_host_model.sv
// Host processor model driving the port's asynchronous pins.
// Assumes tasks are called at the falling edge of mclk.
`timescale 1ns/1ps
module ihbp_host_model (
   // Clock and mode
   input  wire logic       mclk,
   input  wire logic       latchBusSelect,
   input  wire logic       busWidthStrap,
   // Device data side
   input  wire logic [7:0] hostDataLowerOut,
   input  wire logic [7:0] hostDataUpperOut,
   input  wire logic       hostDataOeN,
   // Pins toward the device
   output logic            hostSelectN,
   output logic            hostWriteStrobeN,
   output logic            hostReadStrobeN,
   output logic            indexOrDataSelect,
   output logic            hostLatchEnable,
   output logic [7:0]      hostDataLowerIn,
   output logic [7:0]      hostDataUpperIn
);
   logic [15:0] drv;
   logic [15:0] floatPat;
   logic        drives;
   logic        ownSelect;
   // Released bus toggles every cycle
   always @(negedge mclk)
      floatPat <= ~{hostDataUpperIn, hostDataLowerIn};
   assign {hostDataUpperIn, hostDataLowerIn} = drives ? drv :
      (!hostDataOeN ? {hostDataUpperOut, hostDataLowerOut} : floatPat);
   // Select wired to a data bit on the latch bus
   assign indexOrDataSelect = latchBusSelect ?
      (busWidthStrap ? hostDataLowerIn[1] : hostDataLowerIn[0]) : ownSelect;
   task automatic cyc(int n);
      repeat (n) @(negedge mclk);
   endtask
   task automatic write_word(logic sel, logic cs, logic [15:0] w);
      drives = 1'b1;
      if (latchBusSelect) begin
         drv = {14'h0000, sel, sel};
         hostLatchEnable = 1'b1;
         cyc(5);
         hostLatchEnable = 1'b0;
         cyc(3);
      end else begin
         ownSelect = sel;
      end
      drv = w;
      hostSelectN = cs;
      hostWriteStrobeN = 1'b0;
      cyc(5);
      hostWriteStrobeN = 1'b1;
      cyc(1);
      hostSelectN = 1'b1;
      drives = 1'b0;
      cyc(8);
   endtask
   task automatic read_word(output logic [15:0] w, output logic oe);
      ownSelect = 1'b1;
      hostSelectN = 1'b0;
      hostReadStrobeN = 1'b0;
      cyc(8);
      w = {hostDataUpperIn, hostDataLowerIn};
      oe = hostDataOeN;
      hostReadStrobeN = 1'b1;
      hostSelectN = 1'b1;
   endtask
   initial begin
      {hostSelectN, hostWriteStrobeN, hostReadStrobeN} = 3'b111;
      hostLatchEnable = 1'b0;
      {drives, ownSelect, drv, floatPat} = '0;
   end
endmodule

//--- tb_top.sv
// Self-checking bench of the indirect host bus port.
// Assumes the host model stands on the pins; internal side is driven here.
`timescale 1ns/1ps
module tb_top;
   import ihbp_pkg::*;
   logic mclk = 1'b0, rst_n, busWidthStrap, latchBusSelect, powerSaveEnable;
   logic [1:0] pinFunctionConfig;
   logic hostSelectN, hostWriteStrobeN, hostReadStrobeN, indexOrDataSelect;
   logic hostLatchEnable, hostDataOeN, indexWrite, dataWrite, readStrobe;
   logic [7:0] hostDataLowerIn, hostDataUpperIn, hostDataLowerOut;
   logic [7:0] hostDataUpperOut, regIndex;
   logic [15:0] writeData, readData, got;
   logic indexIsMemory, verticalBlankPeriod, horizontalBlankPeriod, irqRequest;
   logic oe;
   logic [16:0] expQ[$];
   logic [6:0] pinCase [7] = '{7'h0d, 7'h02, 7'h23, 7'h2c, 7'h32, 7'h1c,
                               7'h4e};
   int failures = 0, compares = 0, rsCount = 0, rs0;
   always #20 mclk = ~mclk;
   ihbp_port dut (.mclk, .rst_n, .busWidthStrap, .latchBusSelect,
      .powerSaveEnable, .pinFunctionConfig, .hostSelectN, .hostWriteStrobeN,
      .hostReadStrobeN, .indexOrDataSelect, .hostLatchEnable, .hostDataLowerIn,
      .hostDataUpperIn, .hostDataLowerOut, .hostDataUpperOut, .hostDataOeN,
      .indexWrite, .dataWrite, .writeData, .regIndex, .readStrobe,
      .indexIsMemory, .readData, .verticalBlankPeriod, .horizontalBlankPeriod,
      .irqRequest, .tearOrIrqOut());
   ihbp_host_model host (.mclk, .latchBusSelect, .busWidthStrap,
      .hostDataLowerOut, .hostDataUpperOut, .hostDataOeN, .hostSelectN,
      .hostWriteStrobeN, .hostReadStrobeN, .indexOrDataSelect,
      .hostLatchEnable, .hostDataLowerIn, .hostDataUpperIn);
   task automatic cmpWord(string n, logic [16:0] e, logic [16:0] g);
      compares++;
      if (g !== e) begin
         failures++;
         $display("[ERR] %s expected %h seen %h", n, e, g);
      end
   endtask
   task automatic print_verdict;
      $display("compares %0d failures %0d", compares, failures);
      if (failures == 0 && compares > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask
   // Every write pulse is matched against the model queue
   always @(negedge mclk) begin
      if (readStrobe === 1'b1) rsCount++;
      if (indexWrite === 1'b1 || dataWrite === 1'b1)
         cmpWord("write", expQ.size() ? expQ.pop_front() : '1,
            indexWrite ? {9'h100, regIndex} : {1'b0, writeData});
   end
   task automatic send(logic d, logic [15:0] w);
      if (latchBusSelect) w[busWidthStrap ? 1 : 0] = ~d;
      expQ.push_back(d ? {1'b0, busWidthStrap ? w : {8'h00, w[7:0]}} :
         {9'h100, w[7:0]});
      host.write_word(d, 1'b0, w);
   endtask
   initial begin
      #(40 * 6000);
      failures++;
      print_verdict;
   end
   initial begin
      void'($urandom(99994));
      {rst_n, latchBusSelect, powerSaveEnable, indexIsMemory} = 4'b0000;
      {verticalBlankPeriod, horizontalBlankPeriod, irqRequest} = 3'b000;
      {busWidthStrap, pinFunctionConfig, readData} = {1'b1, 2'b00, 16'h0000};
      repeat (8) @(negedge mclk);
      cmpWord("pin in reset", 0, dut.tearOrIrqOut);
      cmpWord("oe in reset", 1, hostDataOeN);
      rst_n = 1'b1;
      host.cyc(4);
      cmpWord("index reset", INDEX_RESET, regIndex);
      for (int m = 0; m < 4; m++) begin
         {latchBusSelect, busWidthStrap} = m[1:0] ^ 2'b01;
         for (int i = 0; i < 3; i++)
            send(i != 0, $urandom);
      end
      {latchBusSelect, busWidthStrap} = 2'b01;
      host.write_word(1'b1, 1'b1, $urandom);
      for (int k = 0; k < 4; k++) begin
         {indexIsMemory, busWidthStrap} = {k[0], k < 2};
         readData = 16'($urandom);
         rs0 = rsCount;
         host.read_word(got, oe);
         cmpWord("read data", indexIsMemory ? 0 : busWidthStrap ? readData :
            {8'h00, readData[7:0]}, got);
         cmpWord("oe in read", 0, oe);
         host.cyc(8);
         cmpWord("oe after read", 1, hostDataOeN);
         cmpWord("read requests", !indexIsMemory, rsCount - rs0);
      end
      rst_n = 1'b0;
      host.cyc(3);
      cmpWord("data reset", DATA_RESET, writeData);
      cmpWord("index reset", INDEX_RESET, regIndex);
      rst_n = 1'b1;
      host.cyc(4);
      foreach (pinCase[c]) begin
         {pinFunctionConfig, powerSaveEnable, verticalBlankPeriod,
            horizontalBlankPeriod, irqRequest} = pinCase[c][6:1];
         host.cyc(6);
         cmpWord("pin", pinCase[c][0], dut.tearOrIrqOut);
      end
      cmpWord("writes drained", 1, expQ.size() == 0);
      print_verdict;
   end
endmodule
